// file: design/test_gen_pkg.sv
package test_gen_pkg;
	// Transmit segment geometry.
	localparam int DATA_W = 128;
	localparam int BEAT_BYTES = 16;
	localparam int MTY_W = 4;
	localparam int CRC_W = 32;
	localparam int CRC_BYTES = 4;
	// Fixed test packet of 522 bytes.
	localparam int PKT_BYTES = 522;
	localparam int PKT_BEATS = (PKT_BYTES + BEAT_BYTES - 1) / BEAT_BYTES;
	localparam int LAST_BYTES = PKT_BYTES - (PKT_BEATS - 1) * BEAT_BYTES;
	localparam logic [MTY_W-1:0] MTY_PLAIN = MTY_W'(BEAT_BYTES - LAST_BYTES);
	localparam logic [MTY_W-1:0] MTY_CRC =
		MTY_W'(BEAT_BYTES - LAST_BYTES - CRC_BYTES);
	localparam int CRC_LSB = (BEAT_BYTES - LAST_BYTES - CRC_BYTES) * 8;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] PKT_NUM_DEF = 16'h0064;
	localparam int TABLE_DEPTH = 256;
	localparam int TABLE_IDX_W = $clog2(TABLE_DEPTH);
	// Timestamp test packets.
	localparam int PTP_COUNT = 3;
	localparam int PTP_BEATS = 8;
	localparam int CLK_NS = 10;
	localparam int PTP_INIT_NS = 100;
	localparam int PTP_INIT_CYC = (PTP_INIT_NS + CLK_NS - 1) / CLK_NS;
	// Pause sequence.
	localparam logic [8:0] PAUSE_GLOBAL_EN = 9'h100;
	localparam logic [8:0] PAUSE_PRIO_EN = 9'h0ff;
	localparam logic [8:0] PAUSE_GLOBAL_REQ = 9'h100;
	localparam logic [2:0] PRIO_TOP = 3'h7;
	// Example design modes.
	localparam int MODE_DUPLEX = 0;
	localparam int MODE_SIMPLEX_TX = 1;
	localparam int MODE_SIMPLEX_RX = 2;
	// Register map, byte addresses.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_PKT_TARGET = 4'h8;
	localparam int CTRL_RESTART = 0;
	localparam int CTRL_FCS_INS = 1;
	localparam int CTRL_FLOW = 2;
	localparam int CTRL_PTP = 3;
	localparam int CTRL_SIMPLEX_ALIGN = 4;
	localparam int CTRL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h02;
	localparam int STAT_PKT_LSB = 16;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_LOCKED = 4'h1,
		ST_WAIT_ALIGN = 4'h2,
		ST_XFER_INIT = 4'h3,
		ST_TX_ENABLE = 4'h4,
		ST_TX_HALT = 4'h5,
		ST_TX_DONE = 4'h6,
		ST_RESTART_WAIT = 4'h7,
		ST_PTP_INIT = 4'h8,
		ST_PTP_READ = 4'h9,
		ST_PTP_XFER = 4'ha,
		ST_PAUSE_INIT = 4'hb,
		ST_PPP_INIT = 4'hc,
		ST_PAUSE_DONE = 4'hd
	} gen_state_t;
endpackage : test_gen_pkg

// file: design/checksum_if.sv
`timescale 1ns/1ps
interface checksum_if #(parameter int IDX_W = 8);
	logic [IDX_W-1:0] idx;
	logic [31:0] crc;
	modport lookup (input idx, output crc);
	modport requester (output idx, input crc);
endinterface : checksum_if

// file: design/checksum_table.sv
`timescale 1ns/1ps
module checksum_table #(
	parameter int DEPTH = 256,
	parameter logic [31:0] CRC_VALUES [DEPTH] = '{default: 32'h0}
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	checksum_if.lookup port
);
	import test_gen_pkg::*;
	generate
		if (DEPTH < 1 || (1 << $bits(port.idx)) < DEPTH) begin : g_bad
			$error("checksum_table depth does not fit the index");
		end
	endgenerate
	// Registered lookup; values are fixed by the CRC_VALUES parameter, zero for an index out of range.
	wire logic in_range = 32'(port.idx) < DEPTH;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			port.crc <= 32'h0;
		end else begin
			port.crc <= in_range ? CRC_VALUES[port.idx] : 32'h0;
		end
	end
endmodule : checksum_table

// file: design/ethernet_test_packet_generator.sv
`timescale 1ns/1ps
module ethernet_test_packet_generator #(
	parameter int MODE = test_gen_pkg::MODE_DUPLEX
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic reset_done,
	input wire logic rx_aligned,
	input wire logic tx_ready_out,
	input wire logic transmit_overflow_out,
	input wire logic tx_underflow_out,
	input wire logic stat_tx_pause,
	input wire logic stat_tx_pause_valid0,
	input wire logic restart_in,
	input wire logic simplex_aligned_in,
	output logic [test_gen_pkg::DATA_W-1:0] tx_data,
	output logic tx_ena,
	output logic tx_sop,
	output logic tx_eop,
	output logic [test_gen_pkg::MTY_W-1:0] tx_mty,
	output logic ctl_tx_enable,
	output logic ctl_rx_enable,
	output logic ctl_tx_send_rfi,
	output logic [8:0] pause_enable,
	output logic [8:0] pause_req,
	output logic gen_enable,
	output logic mon_enable,
	output logic transceiver_lock_indicator,
	output logic aligned_indicator,
	output logic busy_indicator,
	output logic done_indicator,
	output logic fail_indicator
);
	import test_gen_pkg::*;

	generate
		if (MODE < MODE_DUPLEX || MODE > MODE_SIMPLEX_RX) begin : g_bad_mode
			$error("unsupported example mode");
		end
		if (PKT_BEATS < 2 || LAST_BYTES + CRC_BYTES > BEAT_BYTES) begin : g_bad
			$error("packet size does not fit the checksum placement");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Mode decode.
	localparam logic GEN_ON = (MODE != MODE_SIMPLEX_RX);
	localparam logic MON_ON = (MODE != MODE_SIMPLEX_TX);
	localparam logic SIMPLEX_TX = (MODE == MODE_SIMPLEX_TX);

	gen_state_t state_r, state_nxt;
	logic [CTRL_W-1:0] ctrl_r;
	logic [CNT_W-1:0] target_r, pkt_r, sent_r;
	logic [7:0] beat_r;
	logic [1:0] ptp_idx_r, ptp_sent_r;
	logic [7:0] init_cnt_r;
	logic [2:0] ppp_bit_r;
	logic ptp_flag_r;
	logic rst_sync1_r, rst_sync2_r, sa_sync1_r, sa_sync2_r, restart_prev_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [DATA_W-1:0] data_r;
	logic ena_r, sop_r, eop_r;
	logic [MTY_W-1:0] mty_r;
	logic txen_r, rxen_r, rfi_r, gen_r, mon_r;
	logic lock_r, align_r, busy_r, done_r, fail_r;
	logic [8:0] pen_r, preq_r;

	checksum_if #(.IDX_W(TABLE_IDX_W)) crc_port ();
	checksum_table #(.DEPTH(TABLE_DEPTH)) u_table (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.port(crc_port)
	);
	assign crc_port.idx = pkt_r[TABLE_IDX_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and restart edge.
	wire logic restart_lvl = rst_sync2_r | ctrl_r[CTRL_RESTART];
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rst_sync1_r <= 1'b0;
			rst_sync2_r <= 1'b0;
			sa_sync1_r <= 1'b0;
			sa_sync2_r <= 1'b0;
			restart_prev_r <= 1'b0;
		end else begin
			rst_sync1_r <= restart_in;
			rst_sync2_r <= rst_sync1_r;
			sa_sync1_r <= simplex_aligned_in;
			sa_sync2_r <= sa_sync1_r;
			restart_prev_r <= restart_lvl;
		end
	end

	wire logic restart_edge = restart_lvl & ~restart_prev_r;
	wire logic user_aligned = sa_sync2_r | ctrl_r[CTRL_SIMPLEX_ALIGN];
	wire logic aligned_eff = SIMPLEX_TX ? user_aligned : rx_aligned;
	wire logic fault = transmit_overflow_out | tx_underflow_out;
	wire logic stall = ~tx_ready_out | fault;
	wire logic fcs_ins = ctrl_r[CTRL_FCS_INS];
	wire logic flow_on = ctrl_r[CTRL_FLOW];
	// Modified timestamp frames have no predictable checksum.
	wire logic ptp_go = ctrl_r[CTRL_PTP] & fcs_ins;
	wire logic pkt_last_beat = beat_r == 8'(PKT_BEATS - 1);
	wire logic ptp_last_beat = beat_r == 8'(PTP_BEATS - 1);
	wire logic last_pkt = (pkt_r + 16'h1) >= target_r;
	wire logic ptp_all = ptp_sent_r == 2'(PTP_COUNT);
	wire logic init_done = init_cnt_r == 8'(PTP_INIT_CYC);
	wire logic early = state_r == ST_IDLE || state_r == ST_LOCKED ||
		state_r == ST_WAIT_ALIGN;
	wire logic link_lost = ~early & ~aligned_eff;
	wire logic sending = (state_r == ST_TX_ENABLE || state_r == ST_PTP_XFER) &&
		!stall && !link_lost;
	wire gen_state_t after_ptp = flow_on ? ST_PAUSE_INIT : ST_RESTART_WAIT;

	////////////////////////////////////////////////////////////////////////
	// Generator state machine.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (GEN_ON && reset_done) state_nxt = ST_LOCKED;
			end
			ST_LOCKED: begin
				state_nxt = ST_WAIT_ALIGN;
			end
			ST_WAIT_ALIGN: begin
				if (aligned_eff) state_nxt = ST_XFER_INIT;
			end
			ST_XFER_INIT: begin
				state_nxt = ST_TX_ENABLE;
			end
			ST_TX_ENABLE: begin
				if (stall) state_nxt = ST_TX_HALT;
				else if (pkt_last_beat && last_pkt) state_nxt = ST_TX_DONE;
			end
			ST_TX_HALT: begin
				if (fault) state_nxt = ST_TX_DONE;
				else if (tx_ready_out)
					state_nxt = ptp_flag_r ? ST_PTP_XFER : ST_TX_ENABLE;
			end
			ST_TX_DONE: begin
				if (ptp_go) state_nxt = ST_PTP_INIT;
				else state_nxt = after_ptp;
			end
			ST_RESTART_WAIT: begin
				if (restart_edge) state_nxt = ST_XFER_INIT;
			end
			ST_PTP_INIT: begin
				if (ptp_all) state_nxt = after_ptp;
				else if (init_done) state_nxt = ST_PTP_READ;
			end
			ST_PTP_READ: begin
				state_nxt = ST_PTP_XFER;
			end
			ST_PTP_XFER: begin
				if (stall) state_nxt = ST_TX_HALT;
				else if (ptp_last_beat) state_nxt = ST_PTP_INIT;
			end
			ST_PAUSE_INIT: begin
				if (stat_tx_pause) state_nxt = ST_PPP_INIT;
			end
			ST_PPP_INIT: begin
				if (stat_tx_pause_valid0) state_nxt = ST_PAUSE_DONE;
			end
			ST_PAUSE_DONE: begin
				state_nxt = ST_RESTART_WAIT;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		if (link_lost) state_nxt = ST_IDLE;
	end

	////////////////////////////////////////////////////////////////////////
	// Counters and sequencing state.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			pkt_r <= '0;
			sent_r <= '0;
			beat_r <= '0;
			ptp_idx_r <= '0;
			ptp_sent_r <= '0;
			init_cnt_r <= '0;
			ptp_flag_r <= 1'b0;
			ppp_bit_r <= PRIO_TOP;
		end else begin
			state_r <= state_nxt;
			if (sending) begin
				beat_r <= (pkt_last_beat && !ptp_flag_r) ||
					(ptp_last_beat && ptp_flag_r) ? 8'h0 : beat_r + 8'h1;
			end
			if (sending && !ptp_flag_r && pkt_last_beat) begin
				pkt_r <= pkt_r + 16'h1;
				sent_r <= sent_r + 16'h1;
			end
			if (sending && ptp_flag_r && ptp_last_beat) begin
				ptp_sent_r <= ptp_sent_r + 2'h1;
			end
			case (state_r)
				ST_XFER_INIT, ST_RESTART_WAIT, ST_IDLE: begin
					pkt_r <= '0;
					beat_r <= '0;
					ptp_idx_r <= '0;
					ptp_sent_r <= '0;
					ptp_flag_r <= 1'b0;
					ppp_bit_r <= PRIO_TOP;
					init_cnt_r <= '0;
					if (state_r == ST_XFER_INIT) sent_r <= '0;
				end
				ST_PTP_INIT: begin
					beat_r <= '0;
					ptp_flag_r <= 1'b1;
					init_cnt_r <= init_done ? init_cnt_r : init_cnt_r + 8'h1;
				end
				ST_PTP_READ: begin
					init_cnt_r <= '0;
					if (ptp_sent_r != 2'h0) ptp_idx_r <= ptp_idx_r + 2'h1;
				end
				ST_PPP_INIT: begin
					if (ppp_bit_r != 3'h0) ppp_bit_r <= ppp_bit_r - 3'h1;
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit segment.
	logic [DATA_W-1:0] beat_word;
	always_comb begin
		beat_word = ptp_flag_r ? {8{6'h2a, ptp_idx_r, beat_r}} :
			{8{pkt_r[7:0], beat_r}};
		if (!ptp_flag_r && pkt_last_beat && !fcs_ins)
			beat_word[CRC_LSB +: CRC_W] = crc_port.crc;
	end
	wire logic eop_now = ptp_flag_r ? ptp_last_beat : pkt_last_beat;
	wire logic [MTY_W-1:0] mty_now = ptp_flag_r ? '0 :
		(fcs_ins ? MTY_PLAIN : MTY_CRC);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ena_r <= 1'b0;
			sop_r <= 1'b0;
			eop_r <= 1'b0;
			mty_r <= '0;
			data_r <= '0;
		end else begin
			ena_r <= sending;
			sop_r <= sending && beat_r == 8'h0;
			eop_r <= sending && eop_now;
			mty_r <= sending && eop_now ? mty_now : '0;
			data_r <= sending ? beat_word : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Indicators, MAC controls and pause controls.
	wire logic fail_set = state_r == ST_TX_HALT && fault;
	wire logic fail_clr = state_r == ST_RESTART_WAIT && restart_edge;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			{txen_r, rxen_r, gen_r, mon_r, rfi_r} <= '0;
			{lock_r, align_r, busy_r, done_r, fail_r} <= '0;
			pen_r <= '0;
			preq_r <= '0;
		end else begin
			txen_r <= GEN_ON;
			rxen_r <= MON_ON;
			gen_r <= GEN_ON;
			mon_r <= MON_ON;
			fail_r <= fail_set | (fail_r & ~fail_clr);
			case (state_r)
				ST_IDLE: begin
					{lock_r, align_r, busy_r, rfi_r} <= '0;
				end
				ST_LOCKED: begin
					{rfi_r, busy_r, lock_r} <= 3'h7;
				end
				ST_XFER_INIT: begin
					{align_r, busy_r} <= 2'h3;
					{rfi_r, done_r} <= '0;
				end
				ST_TX_DONE: begin
					done_r <= 1'b1;
				end
				ST_RESTART_WAIT: begin
					busy_r <= 1'b0;
					pen_r <= '0;
					preq_r <= '0;
				end
				ST_PAUSE_INIT: begin
					pen_r <= PAUSE_GLOBAL_EN;
					preq_r <= PAUSE_GLOBAL_REQ;
				end
				ST_PPP_INIT: begin
					pen_r <= PAUSE_PRIO_EN;
					preq_r <= 9'h1 << ppp_bit_r;
				end
				ST_PAUSE_DONE: begin
					pen_r <= '0;
					preq_r <= '0;
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register slave.
	wire logic req = avs_read | avs_write;
	wire logic take_wr = avs_write & ~wait_r;
	wire logic sel_ctrl = avs_address == REG_CTRL;
	wire logic sel_stat = avs_address == REG_STATUS;
	wire logic sel_tgt = avs_address == REG_PKT_TARGET;
	wire logic [31:0] stat_word = {sent_r, 6'h0, ptp_flag_r, fail_r, done_r,
		busy_r, align_r, lock_r, state_r};
	wire logic [31:0] rd_value = sel_ctrl ? {27'h0, ctrl_r} :
		sel_stat ? stat_word : sel_tgt ? {16'h0, target_r} : 32'h0;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0;
			ctrl_r <= CTRL_RESET;
			target_r <= PKT_NUM_DEF;
		end else begin
			wait_r <= ~(req & wait_r);
			if (req && wait_r) rdata_r <= rd_value;
			if (take_wr && sel_ctrl) ctrl_r <= avs_writedata[CTRL_W-1:0];
			if (take_wr && sel_tgt) target_r <= avs_writedata[CNT_W-1:0];
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign tx_data = data_r;
	assign tx_ena = ena_r;
	assign tx_sop = sop_r;
	assign tx_eop = eop_r;
	assign tx_mty = mty_r;
	assign ctl_tx_enable = txen_r;
	assign ctl_rx_enable = rxen_r;
	assign ctl_tx_send_rfi = rfi_r;
	assign pause_enable = pen_r;
	assign pause_req = preq_r;
	assign gen_enable = gen_r;
	assign mon_enable = mon_r;
	assign transceiver_lock_indicator = lock_r;
	assign aligned_indicator = align_r;
	assign busy_indicator = busy_r;
	assign done_indicator = done_r;
	assign fail_indicator = fail_r;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_idle_after_rst: assert property ($rose(rst_b) |-> state_r == ST_IDLE)
		else $error("not idle after reset");
	a_locked_leds: assert property (state_r == ST_LOCKED |=>
		rfi_r && busy_r && lock_r) else $error("locked indicators wrong");
	a_align_hold: assert property (state_r == ST_WAIT_ALIGN && !aligned_eff
		|=> state_r == ST_WAIT_ALIGN) else $error("left alignment wait");
	a_init_enable: assert property (state_r == ST_XFER_INIT && aligned_eff
		|=> state_r == ST_TX_ENABLE && align_r && busy_r)
		else $error("init did not start transmit");
	a_stall_halt: assert property (state_r == ST_TX_ENABLE && stall &&
		aligned_eff |=> state_r == ST_TX_HALT ##1 !tx_ena)
		else $error("stall did not halt");
	a_halt_fail: assert property (state_r == ST_TX_HALT && fault &&
		aligned_eff |=> fail_r && state_r == ST_TX_DONE)
		else $error("fault not flagged");
	a_done_route: assert property (state_r == ST_TX_DONE && aligned_eff
		|=> done_r && state_r == (ptp_go ? ST_PTP_INIT : after_ptp))
		else $error("wrong route after done");
	a_restart_edge: assert property (state_r == ST_RESTART_WAIT &&
		restart_edge && aligned_eff |=> state_r == ST_XFER_INIT && !busy_r)
		else $error("restart edge ignored");
	a_pause_global: assert property (state_r == ST_PAUSE_INIT && aligned_eff
		|=> pause_enable == 9'h100 && pause_req[8])
		else $error("global pause not driven");
	a_ppp_onehot: assert property (state_r == ST_PPP_INIT &&
		$past(state_r) == ST_PPP_INIT |-> $onehot(pause_req) &&
		pause_enable == 9'h0ff) else $error("priority pause wrong");
	a_align_loss: assert property (link_lost |=> state_r == ST_IDLE)
		else $error("alignment loss not handled");
	a_rx_quiet: assert property (!GEN_ON |-> state_r == ST_IDLE &&
		!tx_ena && !ctl_tx_enable) else $error("generator active in rx mode");
	a_crc_mty: assert property (sending && !ptp_flag_r && pkt_last_beat &&
		!fcs_ins |=> tx_eop && tx_mty == MTY_CRC)
		else $error("checksum beat size wrong");
endmodule : ethernet_test_packet_generator

// file: dv/mac_tx_model.sv
`timescale 1ns/1ps
// Transmit side of the MAC: stalls, faults and pause status on command.
module mac_tx_model (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [8:0] pause_req,
	input wire logic [4:0] stall_len,
	input wire logic stall_go,
	input wire logic [1:0] fault_go,
	output logic tx_ready_out,
	output logic transmit_overflow_out,
	output logic tx_underflow_out,
	output logic stat_tx_pause,
	output logic stat_tx_pause_valid0
);
	logic [4:0] stall_r;
	logic [3:0] ps_r;
	logic [3:0] pv_r;
	////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			stall_r <= '0;
			ps_r <= '0;
			pv_r <= '0;
			transmit_overflow_out <= 1'b0;
			tx_underflow_out <= 1'b0;
		end else begin
			stall_r <= stall_go ? stall_len : stall_r - 5'(stall_r != 0);
			ps_r <= {ps_r[2:0], pause_req[8]};
			pv_r <= {pv_r[2:0], pause_req[0]};
			transmit_overflow_out <= fault_go[0];
			tx_underflow_out <= fault_go[1];
		end
	end
	// Pause status answers a few cycles late, as a real core may.
	assign tx_ready_out = rst_b && stall_r == 5'h0;
	assign stat_tx_pause = ps_r[3];
	assign stat_tx_pause_valid0 = pv_r[3];
endmodule : mac_tx_model

// file: dv/ethernet_test_packet_generator_test.sv
`timescale 1ns/1ps
module ethernet_test_packet_generator_test;
	import test_gen_pkg::*;
	logic clk_sys = 0;
	logic rst_b = 0;
	logic [3:0] avs_address = '0;
	logic avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [31:0] avs_writedata = '0, avs_readdata, q;
	logic reset_done = 0, rx_aligned = 0, restart_in = 0, simplex_al = 0;
	logic rdy, ovf, unf, st_p, st_v0, tx_ena, tx_sop, tx_eop;
	logic [DATA_W-1:0] tx_data, ed;
	logic [MTY_W-1:0] tx_mty, em;
	logic c_tx, c_rx, rfi, g_en, m_en, lk, al, bz, dn, fl, es, ee;
	logic [8:0] p_en, p_rq, last;
	wire [4:0] sx;
	wire [5:0] sr;
	logic [4:0] stall_len = 5'h08;
	logic stall_go = 0, fcs = 1;
	logic [1:0] fault_go = 2'h0;
	logic [15:0] seed = 16'h1701;
	int bad_count = 0, compares = 0, beat_n = 0, tgt = 1;
	int p, b, k, i, j, f;
	always #5 clk_sys = ~clk_sys;
	ethernet_test_packet_generator ethernet_test_packet_generator_i (
		.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .reset_done(reset_done),
		.rx_aligned(rx_aligned), .tx_ready_out(rdy),
		.transmit_overflow_out(ovf), .tx_underflow_out(unf),
		.stat_tx_pause(st_p), .stat_tx_pause_valid0(st_v0),
		.restart_in(restart_in), .simplex_aligned_in(simplex_al),
		.tx_data(tx_data), .tx_ena(tx_ena), .tx_sop(tx_sop),
		.tx_eop(tx_eop), .tx_mty(tx_mty), .ctl_tx_enable(c_tx),
		.ctl_rx_enable(c_rx), .ctl_tx_send_rfi(rfi), .pause_enable(p_en),
		.pause_req(p_rq), .gen_enable(g_en), .mon_enable(m_en),
		.transceiver_lock_indicator(lk), .aligned_indicator(al),
		.busy_indicator(bz), .done_indicator(dn), .fail_indicator(fl));
	ethernet_test_packet_generator #(.MODE(MODE_SIMPLEX_TX))
		ethernet_test_packet_generator_tx_i (
		.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(),
		.avs_waitrequest(), .reset_done(reset_done),
		.rx_aligned(rx_aligned), .tx_ready_out(rdy),
		.transmit_overflow_out(ovf), .tx_underflow_out(unf),
		.stat_tx_pause(st_p), .stat_tx_pause_valid0(st_v0),
		.restart_in(restart_in), .simplex_aligned_in(simplex_al),
		.tx_data(), .tx_ena(), .tx_sop(), .tx_eop(), .tx_mty(),
		.ctl_tx_enable(sx[2]), .ctl_rx_enable(sx[1]),
		.ctl_tx_send_rfi(), .pause_enable(), .pause_req(),
		.gen_enable(sx[4]), .mon_enable(sx[3]),
		.transceiver_lock_indicator(), .aligned_indicator(sx[0]),
		.busy_indicator(), .done_indicator(), .fail_indicator());
	ethernet_test_packet_generator #(.MODE(MODE_SIMPLEX_RX))
		ethernet_test_packet_generator_rx_i (
		.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(),
		.avs_waitrequest(), .reset_done(reset_done),
		.rx_aligned(rx_aligned), .tx_ready_out(rdy),
		.transmit_overflow_out(ovf), .tx_underflow_out(unf),
		.stat_tx_pause(st_p), .stat_tx_pause_valid0(st_v0),
		.restart_in(restart_in), .simplex_aligned_in(simplex_al),
		.tx_data(), .tx_ena(sr[1]), .tx_sop(), .tx_eop(), .tx_mty(),
		.ctl_tx_enable(sr[3]), .ctl_rx_enable(sr[2]),
		.ctl_tx_send_rfi(), .pause_enable(), .pause_req(),
		.gen_enable(sr[5]), .mon_enable(sr[4]),
		.transceiver_lock_indicator(sr[0]), .aligned_indicator(),
		.busy_indicator(), .done_indicator(), .fail_indicator());
	mac_tx_model mac_tx_model_i (
		.clk_sys(clk_sys), .rst_b(rst_b), .pause_req(p_rq),
		.stall_len(stall_len), .stall_go(stall_go), .fault_go(fault_go),
		.tx_ready_out(rdy), .transmit_overflow_out(ovf),
		.tx_underflow_out(unf), .stat_tx_pause(st_p),
		.stat_tx_pause_valid0(st_v0));
	////////////////////////////////////////
	function logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task chk(input string nm, input logic [127:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	task wait_state(input logic [3:0] s);
		for (int n = 0; n < 3000; n++) begin
			bus(0, REG_STATUS, 0);
			if (q[3:0] === s) break;
		end
		chk("state", q[3:0], s);
	endtask : wait_state
	task wait_beats(input int n);
		for (int m = 0; m < 3000 && beat_n < n; m++) @(posedge clk_sys);
	endtask : wait_beats
	task restart(input logic [31:0] c);
		beat_n = 0;
		fcs = c[CTRL_FCS_INS];
		bus(1, REG_CTRL, c | 32'h1);
		bus(1, REG_CTRL, c);
	endtask : restart
	task print_verdict;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	////////////////////////////////////////
	// Reference stream: test packets first, then the timestamp packets.
	always @(posedge clk_sys) begin
		if (tx_ena === 1'b1) begin
			k = beat_n - tgt * PKT_BEATS;
			p = k < 0 ? beat_n / PKT_BEATS : k / PTP_BEATS;
			b = k < 0 ? beat_n % PKT_BEATS : k % PTP_BEATS;
			ed = k < 0 ? {8{p[7:0], b[7:0]}} : {8{6'h2a, p[1:0], b[7:0]}};
			es = b == 0;
			ee = b == (k < 0 ? PKT_BEATS : PTP_BEATS) - 1;
			em = (k < 0 && ee) ? (fcs ? MTY_PLAIN : MTY_CRC) : '0;
			if (!(ee && !fcs && k < 0)) chk("tx_data", tx_data, ed);
			else chk("crc_beat", tx_data[DATA_W-1:CRC_LSB],
				{ed[DATA_W-1:CRC_LSB+CRC_W], 32'h0});
			chk("sop_eop_mty", {tx_sop, tx_eop, tx_mty}, {es, ee, em});
			beat_n++;
		end
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		chk("reset_outs", {tx_ena, rfi, p_en, p_rq, bz, dn, fl}, 0);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		bus(0, REG_CTRL, 0);
		chk("ctrl_reset", q, CTRL_RESET);
		bus(0, REG_PKT_TARGET, 0);
		chk("target_reset", q[15:0], 16'h0064);
		bus(1, REG_STATUS, 32'hffff_ffff);
		bus(0, REG_STATUS, 0);
		chk("status_idle", q[8:0], 0);
		bus(1, 4'hc, 32'h1234_5678);
		bus(0, 4'hc, 0);
		chk("unmapped", q, 0);
		chk("mode", {g_en, m_en, c_tx, c_rx}, 4'hf);
		$display("test reset_regs done");
		seed = lfsr(seed);
		tgt = seed % 3 + 1;
		bus(1, REG_PKT_TARGET, 32'(tgt));
		bus(1, REG_CTRL, 32'h2);
		reset_done <= 1'b1;
		wait_state(4'h2);
		chk("locked", {rfi, lk, bz, al}, 4'he);
		rx_aligned <= 1'b1;
		wait_beats(20);
		chk("init", {al, bz}, 2'b11);
		chk("simplex", {sx, sr}, {5'h14, 6'h14});
		simplex_al <= 1'b1;
		seed = lfsr(seed);
		stall_len <= 5'(8 + seed % 8);
		stall_go <= 1'b1;
		@(posedge clk_sys);
		stall_go <= 1'b0;
		wait_state(4'h5);
		wait_state(4'h7);
		chk("beats", beat_n, tgt * PKT_BEATS);
		chk("done", {dn, bz, fl}, 3'b100);
		chk("simplex_align", sx[0], 1'b1);
		$display("test packets done");
		beat_n = 0;
		bus(1, REG_CTRL, 32'he);
		restart_in <= 1'b1;
		repeat (4) @(posedge clk_sys);
		restart_in <= 1'b0;
		for (i = 0; i < 3000 && p_en !== 9'h100; i++) @(posedge clk_sys);
		chk("pause_glob", {p_en, p_rq}, {9'h100, 9'h100});
		chk("ptp_beats", beat_n, tgt * PKT_BEATS + 24);
		for (i = 0; i < 300 && p_en !== 9'h0ff; i++) @(posedge clk_sys);
		j = 7;
		last = '0;
		for (i = 0; i < 300 && p_en === 9'h0ff; i++) begin
			if (p_rq !== last && p_rq !== 9'h0) begin
				chk("ppp_req", p_rq, 9'h1 << j);
				j--;
				last = p_rq;
			end
			@(posedge clk_sys);
		end
		chk("ppp_all", j, -1);
		wait_state(4'h7);
		chk("pause_off", {p_en, p_rq}, 0);
		$display("test ptp_pause done");
		for (f = 0; f < 3; f++) begin
			restart(f == 0 ? 32'h8 : 32'h2);
			wait_beats(10);
			chk("fail_clear", fl, 0);
			fault_go <= 2'(f);
			repeat (4) @(posedge clk_sys);
			fault_go <= 2'h0;
			wait_state(4'h7);
			chk("fail", {fl, dn}, {f != 0, 1'b1});
			if (f == 0) chk("crc_beats", beat_n, tgt * PKT_BEATS);
		end
		$display("test faults done");
		restart(32'h2);
		wait_beats(5);
		rx_aligned <= 1'b0;
		reset_done <= 1'b0;
		wait_state(4'h0);
		chk("tx_quiet", tx_ena, 0);
		beat_n = 0;
		reset_done <= 1'b1;
		rx_aligned <= 1'b1;
		wait_state(4'h7);
		chk("relock_beats", beat_n, tgt * PKT_BEATS);
		$display("test align_loss done");
		print_verdict();
	end
endmodule : ethernet_test_packet_generator_test
